//--- pkg/vswcfg_cfg.svh
// Register map, field positions, reset values and timing for the switch configuration bank.
`ifndef VSWCFG_CFG_SVH
`define VSWCFG_CFG_SVH
// ==========================================================
// Slave address
`define VSWCFG_ADDR_UPPER 6'h24
// ==========================================================
// Register offsets
`define VSWCFG_OFF_FAST_MODE 8'h00
`define VSWCFG_OFF_SIDE_MODE 8'h01
`define VSWCFG_OFF_RX_SET 8'h10
`define VSWCFG_OFF_PULSE_LO 8'h11
`define VSWCFG_OFF_PULSE_HI 8'h12
`define VSWCFG_OFF_EQ_LO 8'h13
`define VSWCFG_OFF_EQ_HI 8'h14
`define VSWCFG_OFF_TX_SET 8'h20
// ==========================================================
// Reset values
`define VSWCFG_RST_FAST_MODE 8'h40
`define VSWCFG_RST_SIDE_MODE 8'h40
`define VSWCFG_RST_RX_SET 8'h01
`define VSWCFG_RST_PULSE_LO 8'h00
`define VSWCFG_RST_PULSE_HI 8'h00
`define VSWCFG_RST_EQ_LO 8'h00
`define VSWCFG_RST_EQ_HI 8'h00
`define VSWCFG_RST_TX_SET 8'h03
// ==========================================================
// Writable bit masks; every other bit is fixed at zero
`define VSWCFG_MSK_MODE 8'h43
`define VSWCFG_MSK_RX_SET 8'h01
`define VSWCFG_MSK_FULL 8'hff
`define VSWCFG_MSK_NIBBLE 8'h0f
`define VSWCFG_MSK_TX_SET 8'h0f
// ==========================================================
// Field positions
`define VSWCFG_POS_ENABLE 6
`define VSWCFG_POS_SOURCE 0
`define VSWCFG_POS_TERM 0
`define VSWCFG_POS_PREEMPH 2
`define VSWCFG_POS_OTERM 1
`define VSWCFG_POS_OCUR 0
// ==========================================================
// Timing
`define VSWCFG_CLK_KHZ 25000
`define VSWCFG_TERM_PULSE_MS 100
`define VSWCFG_TERM_PULSE_CYC (`VSWCFG_TERM_PULSE_MS * `VSWCFG_CLK_KHZ)
`define VSWCFG_UPDATE_DELAY_US 50
`define VSWCFG_UPDATE_DELAY_CYC (`VSWCFG_UPDATE_DELAY_US * `VSWCFG_CLK_KHZ / 1000)
`endif

//--- pkg/vswcfg_pkg.sv
// Types shared by the switch configuration bank.
package vswcfg_pkg;
  // ==========================================================
  // Serial slave states
  typedef enum logic [8:0] {
    VSWCFG_IDLE = 9'h001,
    VSWCFG_ADDR = 9'h002,
    VSWCFG_AACK = 9'h004,
    VSWCFG_REG = 9'h008,
    VSWCFG_RACK = 9'h010,
    VSWCFG_WDAT = 9'h020,
    VSWCFG_WACK = 9'h040,
    VSWCFG_RDAT = 9'h080,
    VSWCFG_MACK = 9'h100
  } vswcfg_state_t;
  // ==========================================================
  // Physical configuration of the switch
  typedef struct packed {
    logic fast_path_enable;
    logic [1:0] fast_path_source;
    logic side_switch_enable;
    logic [1:0] side_switch_source;
    logic input_term_on;
    logic [11:0] term_pulse_on_switch;
    logic [11:0] input_eq_high;
    logic [1:0] output_preemph_level;
    logic output_term_on;
    logic output_current_high;
  } vswcfg_cfg_t;
  // ==========================================================
  // Parallel configuration pins
  typedef struct packed {
    logic enable;
    logic [1:0] source;
    logic eq_high;
    logic [1:0] preemph;
    logic current_high;
  } vswcfg_par_t;
endpackage

//--- core/vswcfg_core.sv
// Serial configuration register bank of a three-input video link switch.
`timescale 1ns/1ns
`include "vswcfg_cfg.svh"
`default_nettype none
module vswcfg_core #(
  parameter int TERM_PULSE_CYC = `VSWCFG_TERM_PULSE_CYC,
  parameter int UPDATE_DELAY_CYC = `VSWCFG_UPDATE_DELAY_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  // Serial pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N_OUT,
  input wire logic SLAVE_ADDR_LSB_PIN_IN,
  // Parallel configuration pins
  input wire vswcfg_pkg::vswcfg_par_t PAR_CFG_IN,
  // Physical configuration
  output vswcfg_pkg::vswcfg_cfg_t SWITCH_CFG_OUT,
  output logic [11:0] CHANNEL_TERM_ON_OUT,
  output logic SERIAL_LOCK_OUT
);
  import vswcfg_pkg::*;

  localparam int WCW = $clog2(UPDATE_DELAY_CYC + 1);
  localparam int PCW = $clog2(TERM_PULSE_CYC + 1);

  generate
    if (TERM_PULSE_CYC < 1 || UPDATE_DELAY_CYC < 1) begin : g_bad_param
      $error("Timing counts must be at least one cycle.");
    end
  endgenerate

  // ==========================================================
  // Register decoding
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    case (a)
      `VSWCFG_OFF_FAST_MODE: reg_index = 4'h8;
      `VSWCFG_OFF_SIDE_MODE: reg_index = 4'h9;
      `VSWCFG_OFF_RX_SET: reg_index = 4'ha;
      `VSWCFG_OFF_PULSE_LO: reg_index = 4'hb;
      `VSWCFG_OFF_PULSE_HI: reg_index = 4'hc;
      `VSWCFG_OFF_EQ_LO: reg_index = 4'hd;
      `VSWCFG_OFF_EQ_HI: reg_index = 4'he;
      `VSWCFG_OFF_TX_SET: reg_index = 4'hf;
      default: reg_index = 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] reg_mask(input logic [2:0] i);
    case (i)
      3'h0, 3'h1: reg_mask = `VSWCFG_MSK_MODE;
      3'h2: reg_mask = `VSWCFG_MSK_RX_SET;
      3'h4, 3'h6: reg_mask = `VSWCFG_MSK_NIBBLE;
      3'h7: reg_mask = `VSWCFG_MSK_TX_SET;
      default: reg_mask = `VSWCFG_MSK_FULL;
    endcase
  endfunction

  function automatic logic [7:0] reg_reset(input logic [2:0] i);
    case (i)
      3'h0: reg_reset = `VSWCFG_RST_FAST_MODE;
      3'h1: reg_reset = `VSWCFG_RST_SIDE_MODE;
      3'h2: reg_reset = `VSWCFG_RST_RX_SET;
      3'h3: reg_reset = `VSWCFG_RST_PULSE_LO;
      3'h4: reg_reset = `VSWCFG_RST_PULSE_HI;
      3'h5: reg_reset = `VSWCFG_RST_EQ_LO;
      3'h6: reg_reset = `VSWCFG_RST_EQ_HI;
      default: reg_reset = `VSWCFG_RST_TX_SET;
    endcase
  endfunction

  // ==========================================================
  // Input synchronisers
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [6:0] par_prev_q;
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      sync1_q <= 10'h3;
      sync2_q <= 10'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      par_prev_q <= 7'h0;
    end else begin
      sync1_q <= {PAR_CFG_IN, SLAVE_ADDR_LSB_PIN_IN, SCL_IN, SDA_IN};
      sync2_q <= sync1_q;
      scl_prev_q <= sync2_q[1];
      sda_prev_q <= sync2_q[0];
      par_prev_q <= sync2_q[9:3];
    end
  end

  wire logic sda_s = sync2_q[0];
  wire logic scl_s = sync2_q[1];
  wire logic addr_lsb_s = sync2_q[2];
  wire vswcfg_par_t par_s = sync2_q[9:3];
  wire logic scl_rise = scl_s & ~scl_prev_q;
  wire logic scl_fall = ~scl_s & scl_prev_q;
  wire logic bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire logic bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire logic [6:0] own_addr = {`VSWCFG_ADDR_UPPER, addr_lsb_s};

  // ==========================================================
  // Serial slave
  vswcfg_state_t st_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic mnack_q;
  logic oe_n_q;
  logic lock_q;
  logic wr_fire_q;
  logic [7:0] regs_q [0:7];

  wire logic [3:0] ptr_idx = reg_index(ptr_q);
  wire logic [3:0] nxt_idx = reg_index(ptr_q + 8'h1);
  wire logic [7:0] rd_cur = ptr_idx[3] ? regs_q[ptr_idx[2:0]] : 8'h00;
  wire logic [7:0] rd_nxt = nxt_idx[3] ? regs_q[nxt_idx[2:0]] : 8'h00;
  wire logic byte_in = (cnt_q == 4'h8);
  wire logic addr_hit = (sh_q[7:1] == own_addr);
  wire logic shifting = (st_q == VSWCFG_ADDR) | (st_q == VSWCFG_REG) | (st_q == VSWCFG_WDAT);

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q <= VSWCFG_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      mnack_q <= 1'b1;
      oe_n_q <= 1'b1;
      lock_q <= 1'b0;
      wr_fire_q <= 1'b0;
    end else begin
      wr_fire_q <= 1'b0;
      if (bus_start) begin
        st_q <= VSWCFG_ADDR;
        cnt_q <= 4'h0;
        oe_n_q <= 1'b1;
      end else if (bus_stop) begin
        st_q <= VSWCFG_IDLE;
        oe_n_q <= 1'b1;
      end else if (scl_rise) begin
        if (shifting) begin
          sh_q <= {sh_q[6:0], sda_s};
          cnt_q <= cnt_q + 4'h1;
        end else if (st_q == VSWCFG_RDAT) begin
          cnt_q <= cnt_q + 4'h1;
        end else if (st_q == VSWCFG_MACK) begin
          mnack_q <= sda_s;
        end
      end else if (scl_fall) begin
        case (st_q)
          VSWCFG_ADDR: begin
            if (byte_in && addr_hit) begin
              rw_q <= sh_q[0];
              oe_n_q <= 1'b0;
              lock_q <= 1'b1;
              st_q <= VSWCFG_AACK;
            end else if (byte_in) begin
              st_q <= VSWCFG_IDLE;
            end
          end
          VSWCFG_AACK: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              sh_q <= rd_cur;
              oe_n_q <= rd_cur[7];
              st_q <= VSWCFG_RDAT;
            end else begin
              oe_n_q <= 1'b1;
              st_q <= VSWCFG_REG;
            end
          end
          VSWCFG_REG: begin
            if (byte_in) begin
              ptr_q <= sh_q;
              oe_n_q <= 1'b0;
              st_q <= VSWCFG_RACK;
            end
          end
          VSWCFG_RACK, VSWCFG_WACK: begin
            oe_n_q <= 1'b1;
            cnt_q <= 4'h0;
            st_q <= VSWCFG_WDAT;
          end
          VSWCFG_WDAT: begin
            if (byte_in) begin
              wr_fire_q <= 1'b1;
              oe_n_q <= 1'b0;
              st_q <= VSWCFG_WACK;
            end
          end
          VSWCFG_RDAT: begin
            if (byte_in) begin
              oe_n_q <= 1'b1;
              st_q <= VSWCFG_MACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_n_q <= sh_q[6];
            end
          end
          VSWCFG_MACK: begin
            cnt_q <= 4'h0;
            if (mnack_q) begin
              st_q <= VSWCFG_IDLE;
            end else begin
              ptr_q <= ptr_q + 8'h1;
              sh_q <= rd_nxt;
              oe_n_q <= rd_nxt[7];
              st_q <= VSWCFG_RDAT;
            end
          end
          default: begin
            oe_n_q <= 1'b1;
          end
        endcase
      end
      if (wr_fire_q) begin
        ptr_q <= ptr_q + 8'h1;
      end
    end
  end

  // ==========================================================
  // Register array
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= reg_reset(3'(i));
      end
    end else if (wr_fire_q && ptr_idx[3]) begin
      regs_q[ptr_idx[2:0]] <= sh_q & reg_mask(ptr_idx[2:0]);
    end
  end

  // ==========================================================
  // Configuration source selection
  vswcfg_cfg_t ser_cfg;
  vswcfg_cfg_t par_cfg;
  assign ser_cfg.fast_path_enable = regs_q[0][`VSWCFG_POS_ENABLE];
  assign ser_cfg.fast_path_source = regs_q[0][`VSWCFG_POS_SOURCE +: 2];
  assign ser_cfg.side_switch_enable = regs_q[1][`VSWCFG_POS_ENABLE];
  assign ser_cfg.side_switch_source = regs_q[1][`VSWCFG_POS_SOURCE +: 2];
  assign ser_cfg.input_term_on = regs_q[2][`VSWCFG_POS_TERM];
  assign ser_cfg.term_pulse_on_switch = {regs_q[4][3:0], regs_q[3]};
  assign ser_cfg.input_eq_high = {regs_q[6][3:0], regs_q[5]};
  assign ser_cfg.output_preemph_level = regs_q[7][`VSWCFG_POS_PREEMPH +: 2];
  assign ser_cfg.output_term_on = regs_q[7][`VSWCFG_POS_OTERM];
  assign ser_cfg.output_current_high = regs_q[7][`VSWCFG_POS_OCUR];
  assign par_cfg.fast_path_enable = par_s.enable;
  assign par_cfg.fast_path_source = par_s.source;
  assign par_cfg.side_switch_enable = 1'b1;
  assign par_cfg.side_switch_source = par_s.source;
  assign par_cfg.input_term_on = 1'b1;
  assign par_cfg.term_pulse_on_switch = 12'h000;
  assign par_cfg.input_eq_high = {12{par_s.eq_high}};
  assign par_cfg.output_preemph_level = par_s.preemph;
  assign par_cfg.output_term_on = 1'b1;
  assign par_cfg.output_current_high = par_s.current_high;
  wire vswcfg_cfg_t eff_cfg = lock_q ? ser_cfg : par_cfg;

  // ==========================================================
  // Update window and termination pulse
  // A change request is registered one cycle so the array already holds the new byte.
  wire logic par_change = ~lock_q & (par_s != par_prev_q);
  wire logic lock_set = scl_fall & (st_q == VSWCFG_ADDR) & byte_in & addr_hit & ~lock_q;
  logic commit_q;
  logic pending_q;
  logic [WCW-1:0] win_q;
  logic [PCW-1:0] pulse_q;
  vswcfg_cfg_t applied_q;
  wire logic win_open = (win_q != '0);
  wire logic apply_now = commit_q & ~win_open;
  wire logic apply_late = pending_q & (win_q == WCW'(1));
  wire logic do_apply = apply_now | apply_late;
  wire logic src_moves = do_apply & (eff_cfg.fast_path_source != applied_q.fast_path_source);

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      commit_q <= 1'b1;
      pending_q <= 1'b0;
      win_q <= '0;
      applied_q <= '0;
      pulse_q <= '0;
    end else begin
      commit_q <= wr_fire_q | par_change | lock_set;
      if (apply_now) begin
        win_q <= WCW'(UPDATE_DELAY_CYC);
      end else if (win_open) begin
        win_q <= win_q - WCW'(1);
      end
      if (apply_now || apply_late) begin
        pending_q <= 1'b0;
      end
      if (commit_q && win_open) begin
        pending_q <= 1'b1;
      end
      if (do_apply) begin
        applied_q <= eff_cfg;
      end
      if (src_moves) begin
        pulse_q <= PCW'(TERM_PULSE_CYC);
      end else if (pulse_q != '0) begin
        pulse_q <= pulse_q - PCW'(1);
      end
    end
  end

  // ==========================================================
  // Outputs
  logic [11:0] term_q;
  wire logic pulsing = (pulse_q != '0);
  wire logic [11:0] term_d = {12{applied_q.input_term_on}} &
    ~({12{pulsing}} & applied_q.term_pulse_on_switch);

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      term_q <= 12'h000;
    end else begin
      term_q <= term_d;
    end
  end

  assign SWITCH_CFG_OUT = applied_q;
  assign CHANNEL_TERM_ON_OUT = term_q;
  assign SERIAL_LOCK_OUT = lock_q;
  assign SDA_OE_N_OUT = oe_n_q;
  assign SDA_OUT = 1'b0;

endmodule
`default_nettype wire

//--- verif/vswcfg_core_assertions.sv
// Concurrent checks on the ports of the switch configuration bank.
`timescale 1ns/1ns
`default_nettype none
module vswcfg_core_assertions #(
  parameter int TERM_PULSE_CYC = 20
) (
  // Clock, reset and serial pins
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N_OUT,
  // Applied configuration
  input wire vswcfg_pkg::vswcfg_cfg_t SWITCH_CFG_OUT,
  input wire logic [11:0] CHANNEL_TERM_ON_OUT,
  input wire logic SERIAL_LOCK_OUT
);
  import vswcfg_pkg::*;
  logic [31:0] low_cnt_q;
  logic [31:0] low_cnt_d;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // ==========================================================
  // Pulse length meter
  assign low_cnt_d = CHANNEL_TERM_ON_OUT[0] ? 32'h0 : low_cnt_q + 32'h1;
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      low_cnt_q <= 32'h0;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end
  // ==========================================================
  // Properties
  a_sda_open_drain: assert property (SDA_OUT == 1'b0)
    else $error("data pin driven high");
  a_ack_holds: assert property ($fell(SDA_OE_N_OUT) |-> !SDA_OE_N_OUT [*4])
    else $error("drive too short");
  a_drive_scl_low: assert property ($changed(SDA_OE_N_OUT) |-> !$past(SCL_IN, 2))
    else $error("data changed while clock high");
  a_lock_sticky: assert property (SERIAL_LOCK_OUT |=> SERIAL_LOCK_OUT)
    else $error("lock dropped");
  a_lock_on_ack: assert property ($rose(SERIAL_LOCK_OUT) |-> ##[0:2] !SDA_OE_N_OUT)
    else $error("lock without acknowledge");
  a_pulse_drop: assert property ($changed(SWITCH_CFG_OUT.fast_path_source) &&
    SWITCH_CFG_OUT.input_term_on |=>
    (CHANNEL_TERM_ON_OUT & SWITCH_CFG_OUT.term_pulse_on_switch) == 12'h000)
    else $error("termination not pulsed");
  a_pulse_length: assert property ($rose(CHANNEL_TERM_ON_OUT[0]) &&
    SWITCH_CFG_OUT.term_pulse_on_switch[0] |-> low_cnt_q == TERM_PULSE_CYC)
    else $error("pulse length wrong");
  a_steady_term: assert property ($past(SWITCH_CFG_OUT.input_term_on) &&
    SWITCH_CFG_OUT.input_term_on |->
    (CHANNEL_TERM_ON_OUT | $past(SWITCH_CFG_OUT.term_pulse_on_switch)) == 12'hfff)
    else $error("termination dropped");
  a_term_off: assert property (!$past(SWITCH_CFG_OUT.input_term_on) |->
    CHANNEL_TERM_ON_OUT == 12'h000) else $error("termination on while off");
endmodule
bind vswcfg_core vswcfg_core_assertions #(.TERM_PULSE_CYC(TERM_PULSE_CYC)) u_chk (
  .CORE_CLK_IN(CORE_CLK_IN),
  .RST_N_IN(RST_N_IN),
  .SCL_IN(SCL_IN),
  .SDA_OUT(SDA_OUT),
  .SDA_OE_N_OUT(SDA_OE_N_OUT),
  .SWITCH_CFG_OUT(SWITCH_CFG_OUT),
  .CHANNEL_TERM_ON_OUT(CHANNEL_TERM_ON_OUT),
  .SERIAL_LOCK_OUT(SERIAL_LOCK_OUT)
);
`default_nettype wire

//--- verif/vswcfg_i2c_master.sv
// Serial bus master model that drives the bank's two-wire pins.
`timescale 1ns/1ns
`default_nettype none
module vswcfg_i2c_master (
  // Clock and shared data wire
  input wire logic clk_in,
  input wire logic sda_in,
  // Driven lines, released high
  output logic scl_out,
  output logic sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Data moves two cycles after the clock falls so no stray start or stop is seen.
  task automatic q(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  task automatic start();
    q(2);
    sda_out = 1'b1;
    q(6);
    scl_out = 1'b1;
    q(8);
    sda_out = 1'b0;
    q(8);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    q(2);
    sda_out = 1'b0;
    q(6);
    scl_out = 1'b1;
    q(8);
    sda_out = 1'b1;
    q(8);
  endtask
  // Nine slots, most significant first; the last is the acknowledge.
  task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      q(2);
      sda_out = tx[i];
      q(6);
      scl_out = 1'b1;
      q(8);
      rx[i] = sda_in;
      scl_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- verif/vswcfg_core_bench.sv
// Self-checking bench for the switch configuration bank.
`timescale 1ns/1ns
`include "vswcfg_cfg.svh"
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module vswcfg_core_bench;
  import vswcfg_pkg::*;
  localparam int UPD = 1000;
  logic clk = 1'b0;
  logic rst_n, scl, sda_m, sda_w, strap, lock, sda_o, sda_oe_n;
  vswcfg_par_t par;
  vswcfg_cfg_t cfg;
  logic [11:0] term, term_and;
  logic [8:0] rx;
  int n_errors = 0;
  int comparisons = 0;
  logic [7:0] offs [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20};
  logic [7:0] rsts [8] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  logic [7:0] msks [8] = '{8'h43, 8'h43, 8'h01, 8'hff, 8'h0f, 8'hff, 8'h0f, 8'h0f};
  // Open-drain wire with pull-up.
  assign sda_w = sda_m & (sda_oe_n | sda_o);
  initial begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) term_and <= term_and & term;
  vswcfg_core #(.TERM_PULSE_CYC(20), .UPDATE_DELAY_CYC(UPD)) u_dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_o),
    .SDA_OE_N_OUT(sda_oe_n), .SLAVE_ADDR_LSB_PIN_IN(strap), .PAR_CFG_IN(par),
    .SWITCH_CFG_OUT(cfg), .CHANNEL_TERM_ON_OUT(term), .SERIAL_LOCK_OUT(lock));
  vswcfg_i2c_master u_mst (.clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_m));
  // ==========================================================
  // Access tasks
  task automatic wr(input logic [7:0] off, input logic [7:0] d, input int n);
    u_mst.start();
    u_mst.xbyte({`VSWCFG_ADDR_UPPER, strap, 2'b01}, rx);
    `CHK("addr ack", 1'b0, rx[0])
    u_mst.xbyte({off, 1'b1}, rx);
    `CHK("offset ack", 1'b0, rx[0])
    u_mst.xbyte({d, 1'b1}, rx);
    `CHK("data ack", 1'b0, rx[0])
    u_mst.stop();
    u_mst.q(n);
  endtask
  task automatic rd(input logic [7:0] off, input logic [7:0] e);
    logic [2:0] ak;
    u_mst.start();
    u_mst.xbyte({`VSWCFG_ADDR_UPPER, strap, 2'b01}, rx);
    ak[0] = rx[0];
    u_mst.xbyte({off, 1'b1}, rx);
    ak[1] = rx[0];
    u_mst.start();
    u_mst.xbyte({`VSWCFG_ADDR_UPPER, strap, 2'b11}, rx);
    ak[2] = rx[0];
    u_mst.xbyte(9'h1ff, rx);
    u_mst.stop();
    `CHK("read acks", 3'b000, ak)
    `CHK("read data", e, rx[8:1])
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  // ==========================================================
  // Tests
  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    par = '{1'b1, 2'b10, 1'b1, 2'b01, 1'b1};
    term_and = 12'hfff;
    repeat (5) @(posedge clk);
    #2;
    rst_n = 1'b1;
    u_mst.q(UPD + 10);
    `CHK("pin source", 2'b10, cfg.fast_path_source)
    `CHK("pin eq", 12'hfff, cfg.input_eq_high)
    `CHK("lock idle", 1'b0, lock)
    $display("test parallel done");
    for (int i = 0; i < 8; i++) rd(offs[i], rsts[i]);
    `CHK("lock set", 1'b1, lock)
    `CHK("serial source", 2'b00, cfg.fast_path_source)
    `CHK("fast on", 1'b1, cfg.fast_path_enable)
    par.source = 2'b01;
    u_mst.q(UPD);
    `CHK("pins ignored", 2'b00, cfg.fast_path_source)
    $display("test reset values done");
    // Source fields get 10 here, never the forbidden 11.
    for (int i = 0; i < 8; i++) wr(offs[i], (i < 2) ? 8'hfe : 8'hff, 0);
    wr(8'h05, 8'hff, UPD);
    for (int i = 0; i < 8; i++) rd(offs[i], ((i < 2) ? 8'hfe : 8'hff) & msks[i]);
    rd(8'h05, 8'h00);
    `CHK("pulse bits", 12'hfff, cfg.term_pulse_on_switch)
    `CHK("tx bits", 4'hf, {cfg.output_preemph_level, cfg.output_term_on, cfg.output_current_high})
    $display("test masks done");
    wr(8'h11, 8'h5b, 0);
    wr(8'h12, 8'h03, UPD);
    for (int s = 0; s < 3; s++) begin
      term_and = 12'hfff;
      wr(8'h00, 8'h40 | 8'(s), UPD);
      `CHK("fast source", 2'(s), cfg.fast_path_source)
      `CHK("pulse low", 12'hca4, term_and)
      `CHK("term back", 12'hfff, term)
      wr(8'h01, 8'h40 | 8'(s), UPD);
      `CHK("side source", 2'(s), cfg.side_switch_source)
    end
    wr(8'h00, 8'h01, UPD);
    `CHK("fast off", 1'b0, cfg.fast_path_enable)
    wr(8'h01, 8'h01, UPD);
    `CHK("side off", 1'b0, cfg.side_switch_enable)
    wr(8'h10, 8'h00, UPD);
    `CHK("term off", 12'h000, term)
    $display("test modes done");
    wr(8'h00, 8'h40, 0);
    wr(8'h00, 8'h42, 0);
    `CHK("held", 2'b00, cfg.fast_path_source)
    u_mst.q(600);
    `CHK("applied", 2'b10, cfg.fast_path_source)
    $display("test update window done");
    strap = 1'b1;
    u_mst.q(4);
    u_mst.start();
    u_mst.xbyte({`VSWCFG_ADDR_UPPER, 1'b0, 2'b01}, rx);
    u_mst.stop();
    `CHK("wrong addr", 1'b1, rx[0])
    rd(8'h00, 8'h42);
    $display("test address done");
    stop_test();
  end
endmodule
`default_nettype wire
